/* design/pbc_pkg.sv */
// Purpose: Constants for the transceiver basic control and status register pair
// Assumes: Avalon-MM slave with 32-bit data, one aligned word per register index
// Notes: Byte address of a register is four times its index

package pbc_pkg;

    // ****************************************
    // Bus geometry
    // ****************************************
    localparam int ADDR_W = 12;
    localparam int IDX_W = 10;

    // ****************************************
    // Register indexes
    // ****************************************
    localparam logic [IDX_W-1:0] IDX_CTRL = 10'h100;
    localparam logic [IDX_W-1:0] IDX_STAT = 10'h102;
    localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 10'h110;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 10'h111;

    // ****************************************
    // Control field positions
    // ****************************************
    localparam int CTRL_SOFT_RESET = 15;
    localparam int CTRL_LOOPBACK = 14;
    localparam int CTRL_SPEED_100 = 13;
    localparam int CTRL_AN_EN = 12;
    localparam int CTRL_POWER_DOWN = 11;
    localparam int CTRL_ISOLATE = 10;
    localparam int CTRL_AN_RESTART = 9;
    localparam int CTRL_DUPLEX = 8;
    localparam int CTRL_COL_TEST = 7;

    // ****************************************
    // Control reset values
    // ****************************************
    localparam logic RST_LOOPBACK = 1'b0;
    localparam logic RST_POWER_DOWN = 1'b0;
    localparam logic RST_ISOLATE = 1'b0;
    localparam logic RST_AN_RESTART = 1'b0;
    localparam logic RST_DUPLEX = 1'b1;
    localparam logic RST_COL_TEST = 1'b0;

    // ****************************************
    // Status field positions
    // ****************************************
    localparam int STAT_AN_DONE = 5;
    localparam int STAT_FAR_FAULT = 4;
    localparam int STAT_LINK_UP = 2;
    localparam int STAT_JABBER = 1;

    // Capability bits 14..11, no-preamble bit 6, AN ability bit 3, extended bit 0
    localparam logic [15:0] STAT_FIXED = 16'h7849;

    // ****************************************
    // Interrupt bit positions
    // ****************************************
    localparam int IRQ_W = 4;
    localparam int IRQ_LINK_DOWN = 0;
    localparam int IRQ_FAR_FAULT = 1;
    localparam int IRQ_JABBER = 2;
    localparam int IRQ_AN_DONE = 3;
    localparam logic [IRQ_W-1:0] RST_IRQ = 4'h0;

endpackage

/* design/pbc_regs.sv */
// Purpose: Basic control and status registers of one integrated transceiver port
// Assumes: Live condition inputs and straps are synchronous to CLK_I
// Notes: One wait state on every bus access; latching bits clear on status read

`timescale 1ns/10ps

// Notes on behaviour
// - While powered down, link status is not refreshed; software treats link as down.
// - Power-down going from one to zero pulses an internal transceiver reset.
// - Control bit 10 isolates the transceiver from the switch core; resets zero.
// - Writing one to control bit 9 restarts auto-negotiation; bit clears itself.
// - Control bit 8 forces duplex, resets one; ignored while auto-negotiation enabled.
// - Control bit 7 enables the collision signal test; resets zero.
// - Speed select and auto-negotiation enable reset from strap inputs.
// - Status bits 15..11 are constants: 0,1,1,1,1.
// - Status bit 8 reads zero; no extended status.
// - Status bit 6 reads one; frames without preamble accepted.
// - Status bit 5 shows auto-negotiation complete, live.
// - Far-end fault and jabber latch high; link up latches low until read.
// - Status bit 3 reads constant one; auto-negotiation ability.
// - Status bit 0 reads constant one; extended register set supported.
// - Control bit 11 selects power-down when one, normal operation when zero.
// - Control bit 12 enables auto-negotiation; software may overwrite strap value.
module pbc_regs
    import pbc_pkg::*;
(
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    input wire logic [ADDR_W-1:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    input wire logic [3:0] AVS_BYTEENABLE_I,
    output logic [31:0] AVS_READDATA_O,
    output logic AVS_WAITREQUEST_O,
    input wire logic STRAP_SPEED_100_I,
    input wire logic STRAP_AN_EN_I,
    input wire logic LINK_UP_I,
    input wire logic FAR_FAULT_I,
    input wire logic JABBER_I,
    input wire logic AN_DONE_I,
    input wire logic AN_FULL_DUPLEX_I,
    input wire logic AN_SPEED_100_I,
    output logic POWER_DOWN_O,
    output logic ISOLATE_O,
    output logic AN_ENABLE_O,
    output logic AN_RESTART_O,
    output logic XCVR_RESET_O,
    output logic LOOPBACK_O,
    output logic COL_TEST_O,
    output logic FULL_DUPLEX_O,
    output logic SPEED_100_O,
    output logic IRQ_O
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic loopback;
        logic speed_100;
        logic an_en;
        logic power_down;
        logic isolate;
        logic an_restart;
        logic duplex;
        logic col_test;
        logic soft_reset;
        logic pd_exit_reset;
        logic full_duplex_eff;
        logic speed_100_eff;
        logic far_fault_lat;
        logic link_lat;
        logic jabber_lat;
        logic link_prev;
        logic fault_prev;
        logic jabber_prev;
        logic an_done_prev;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic ack;
        logic [31:0] rdata;
    } pbc_state_s;

    pbc_state_s q_r;
    pbc_state_s q_nxt;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [15:0] pbc_merge(input logic [15:0] old, input logic [15:0] wd,
                                              input logic [1:0] be);
        logic [15:0] res;
        res = old;
        if (be[0]) begin
            res[7:0] = wd[7:0];
        end
        if (be[1]) begin
            res[15:8] = wd[15:8];
        end
        return res;
    endfunction

    function automatic logic [15:0] pbc_ctrl_word(input pbc_state_s s);
        logic [15:0] w;
        w = 16'h0000;
        w[CTRL_SOFT_RESET] = s.soft_reset;
        w[CTRL_LOOPBACK] = s.loopback;
        w[CTRL_SPEED_100] = s.speed_100;
        w[CTRL_AN_EN] = s.an_en;
        w[CTRL_POWER_DOWN] = s.power_down;
        w[CTRL_ISOLATE] = s.isolate;
        w[CTRL_AN_RESTART] = s.an_restart;
        w[CTRL_DUPLEX] = s.duplex;
        w[CTRL_COL_TEST] = s.col_test;
        return w;
    endfunction

    // ****************************************
    // Next state
    // ****************************************
    logic req;
    logic take;
    logic [IDX_W-1:0] idx;
    logic [15:0] stat_word;
    logic [15:0] ctrl_w;
    logic [IRQ_W-1:0] ev;
    logic stat_read;

    always_comb begin
        q_nxt = q_r;
        req = AVS_READ_I | AVS_WRITE_I;
        take = req & q_r.ack;
        idx = AVS_ADDRESS_I[ADDR_W-1:2];
        stat_read = take & AVS_READ_I & (idx == IDX_STAT);
        ctrl_w = pbc_merge(pbc_ctrl_word(q_r), AVS_WRITEDATA_I[15:0], AVS_BYTEENABLE_I[1:0]);

        stat_word = STAT_FIXED;
        stat_word[STAT_AN_DONE] = AN_DONE_I;
        stat_word[STAT_FAR_FAULT] = q_r.far_fault_lat;
        stat_word[STAT_LINK_UP] = q_r.link_lat;
        stat_word[STAT_JABBER] = q_r.jabber_lat;

        // Self-clearing pulses
        q_nxt.an_restart = 1'b0;
        q_nxt.soft_reset = 1'b0;
        q_nxt.pd_exit_reset = 1'b0;

        // Bus handshake: one wait state, data captured in the waiting cycle
        q_nxt.ack = req & ~q_r.ack;
        if (req & ~q_r.ack) begin
            q_nxt.rdata = 32'h0000_0000;
            if (AVS_READ_I) begin
                if (idx == IDX_CTRL) begin
                    q_nxt.rdata[15:0] = pbc_ctrl_word(q_r);
                end else if (idx == IDX_STAT) begin
                    q_nxt.rdata[15:0] = stat_word;
                end else if (idx == IDX_IRQ_STAT) begin
                    q_nxt.rdata[IRQ_W-1:0] = q_r.irq_stat;
                end else if (idx == IDX_IRQ_MASK) begin
                    q_nxt.rdata[IRQ_W-1:0] = q_r.irq_mask;
                end
            end
        end

        // Latching status; only what the read reported is released
        q_nxt.far_fault_lat = q_r.far_fault_lat | FAR_FAULT_I;
        q_nxt.jabber_lat = q_r.jabber_lat | JABBER_I;
        q_nxt.link_lat = q_r.link_lat & LINK_UP_I;
        if (stat_read) begin
            q_nxt.far_fault_lat = (q_r.rdata[STAT_FAR_FAULT] ? 1'b0 : q_r.far_fault_lat) | FAR_FAULT_I;
            q_nxt.jabber_lat = (q_r.rdata[STAT_JABBER] ? 1'b0 : q_r.jabber_lat) | JABBER_I;
            q_nxt.link_lat = (q_r.rdata[STAT_LINK_UP] ? q_r.link_lat : 1'b1) & LINK_UP_I;
        end
        if (q_r.power_down) begin
            q_nxt.link_lat = q_r.link_lat;
        end

        // Events
        ev = '0;
        ev[IRQ_LINK_DOWN] = q_r.link_prev & ~LINK_UP_I & ~q_r.power_down;
        ev[IRQ_FAR_FAULT] = FAR_FAULT_I & ~q_r.fault_prev;
        ev[IRQ_JABBER] = JABBER_I & ~q_r.jabber_prev;
        ev[IRQ_AN_DONE] = AN_DONE_I & ~q_r.an_done_prev;
        q_nxt.link_prev = LINK_UP_I;
        q_nxt.fault_prev = FAR_FAULT_I;
        q_nxt.jabber_prev = JABBER_I;
        q_nxt.an_done_prev = AN_DONE_I;

        // Register writes
        if (take & AVS_WRITE_I) begin
            if (idx == IDX_CTRL) begin
                q_nxt.soft_reset = ctrl_w[CTRL_SOFT_RESET];
                q_nxt.loopback = ctrl_w[CTRL_LOOPBACK];
                q_nxt.speed_100 = ctrl_w[CTRL_SPEED_100];
                q_nxt.an_en = ctrl_w[CTRL_AN_EN];
                q_nxt.power_down = ctrl_w[CTRL_POWER_DOWN];
                q_nxt.isolate = ctrl_w[CTRL_ISOLATE];
                q_nxt.an_restart = ctrl_w[CTRL_AN_RESTART];
                q_nxt.duplex = ctrl_w[CTRL_DUPLEX];
                q_nxt.col_test = ctrl_w[CTRL_COL_TEST];
            end else if (idx == IDX_IRQ_STAT) begin
                q_nxt.irq_stat = q_r.irq_stat & ~AVS_WRITEDATA_I[IRQ_W-1:0];
            end else if (idx == IDX_IRQ_MASK) begin
                q_nxt.irq_mask = AVS_WRITEDATA_I[IRQ_W-1:0];
            end
        end
        // A new event wins over a simultaneous clear
        q_nxt.irq_stat = q_nxt.irq_stat | ev;

        if (q_r.power_down & ~q_nxt.power_down) begin
            q_nxt.pd_exit_reset = 1'b1;
        end

        // Forced modes apply only without auto-negotiation
        q_nxt.full_duplex_eff = q_nxt.an_en ? AN_FULL_DUPLEX_I : q_nxt.duplex;
        q_nxt.speed_100_eff = q_nxt.an_en ? AN_SPEED_100_I : q_nxt.speed_100;

        if (SYS_RST_I) begin
            q_nxt = '0;
            q_nxt.loopback = RST_LOOPBACK;
            q_nxt.speed_100 = STRAP_SPEED_100_I;
            q_nxt.an_en = STRAP_AN_EN_I;
            q_nxt.power_down = RST_POWER_DOWN;
            q_nxt.isolate = RST_ISOLATE;
            q_nxt.an_restart = RST_AN_RESTART;
            q_nxt.duplex = RST_DUPLEX;
            q_nxt.col_test = RST_COL_TEST;
            q_nxt.full_duplex_eff = STRAP_AN_EN_I ? AN_FULL_DUPLEX_I : RST_DUPLEX;
            q_nxt.speed_100_eff = STRAP_AN_EN_I ? AN_SPEED_100_I : STRAP_SPEED_100_I;
            q_nxt.far_fault_lat = FAR_FAULT_I;
            q_nxt.jabber_lat = JABBER_I;
            q_nxt.link_lat = LINK_UP_I;
            q_nxt.link_prev = LINK_UP_I;
            q_nxt.fault_prev = FAR_FAULT_I;
            q_nxt.jabber_prev = JABBER_I;
            q_nxt.an_done_prev = AN_DONE_I;
            q_nxt.irq_stat = RST_IRQ;
            q_nxt.irq_mask = RST_IRQ;
        end
    end

    always_ff @(posedge CLK_I) begin
        q_r <= q_nxt;
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign AVS_WAITREQUEST_O = (AVS_READ_I | AVS_WRITE_I) & ~q_r.ack;
    assign AVS_READDATA_O = q_r.rdata;
    assign POWER_DOWN_O = q_r.power_down;
    assign ISOLATE_O = q_r.isolate;
    assign AN_ENABLE_O = q_r.an_en;
    assign AN_RESTART_O = q_r.an_restart;
    assign XCVR_RESET_O = q_r.pd_exit_reset | q_r.soft_reset;
    assign LOOPBACK_O = q_r.loopback;
    assign COL_TEST_O = q_r.col_test;
    assign FULL_DUPLEX_O = q_r.full_duplex_eff;
    assign SPEED_100_O = q_r.speed_100_eff;
    assign IRQ_O = |(q_r.irq_stat & q_r.irq_mask);

endmodule

/* sim/pbc_regs_sva.sv */
// Purpose: Port-level assertions for the basic control and status registers
// Assumes: Byte enables all set by the bench; one wait state per access
// Notes: Bound to pbc_regs from the bench top file
`timescale 1ns/10ps
module pbc_regs_sva
    import pbc_pkg::*;
(
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    input wire logic [ADDR_W-1:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    input wire logic [31:0] AVS_READDATA_O,
    input wire logic AVS_WAITREQUEST_O,
    input wire logic LINK_UP_I,
    input wire logic FAR_FAULT_I,
    input wire logic JABBER_I,
    input wire logic AN_DONE_I,
    input wire logic AN_FULL_DUPLEX_I,
    input wire logic POWER_DOWN_O,
    input wire logic ISOLATE_O,
    input wire logic AN_ENABLE_O,
    input wire logic AN_RESTART_O,
    input wire logic XCVR_RESET_O,
    input wire logic COL_TEST_O,
    input wire logic FULL_DUPLEX_O
);
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (SYS_RST_I);
    logic wr_ctrl;
    logic rd_stat;
    logic [15:0] wd_q;
    assign wr_ctrl = AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I[11:2] == IDX_CTRL;
    assign rd_stat = AVS_READ_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I[11:2] == IDX_STAT;
    always_ff @(posedge CLK_I) begin
        wd_q <= AVS_WRITEDATA_I[15:0];
    end
    property p_fixed;
        rd_stat |-> (AVS_READDATA_O & 32'hFFFF_FFC9) == {16'h0000, STAT_FIXED};
    endproperty
    a_fixed: assert property (p_fixed) else $error("fixed status bits wrong");
    property p_an_done;
        rd_stat |-> AVS_READDATA_O[5] == $past(AN_DONE_I);
    endproperty
    a_an_done: assert property (p_an_done) else $error("negotiation done bit wrong");
    property p_hi_latch;
        rd_stat && $past(FAR_FAULT_I, 2) && $past(JABBER_I, 2) |-> AVS_READDATA_O[4] && AVS_READDATA_O[1];
    endproperty
    a_hi_latch: assert property (p_hi_latch) else $error("fault or jabber not held");
    property p_lo_latch;
        rd_stat && !$past(LINK_UP_I, 2) && !$past(POWER_DOWN_O, 2) |-> !AVS_READDATA_O[2];
    endproperty
    a_lo_latch: assert property (p_lo_latch) else $error("link loss not held");
    property p_restart;
        wr_ctrl && AVS_WRITEDATA_I[9] |=> AN_RESTART_O ##1 !AN_RESTART_O;
    endproperty
    a_restart: assert property (p_restart) else $error("restart not a single pulse");
    property p_fields;
        wr_ctrl |=> {POWER_DOWN_O, ISOLATE_O, AN_ENABLE_O, COL_TEST_O} == {wd_q[11], wd_q[10], wd_q[12], wd_q[7]};
    endproperty
    a_fields: assert property (p_fields) else $error("control outputs differ from write");
    property p_duplex;
        AN_ENABLE_O |-> FULL_DUPLEX_O == $past(AN_FULL_DUPLEX_I);
    endproperty
    a_duplex: assert property (p_duplex) else $error("duplex not from negotiation");
    property p_wake;
        wr_ctrl && POWER_DOWN_O && !AVS_WRITEDATA_I[11] |=> XCVR_RESET_O;
    endproperty
    a_wake: assert property (p_wake) else $error("no reset on power-up");
endmodule

/* sim/test_phy_basic_ctrl_status_regs.sv */
// Purpose: Self-checking bench for the basic control and status registers
// Assumes: Avalon-MM master waits for waitrequest low on every access
// Notes: Power-down exit is the last step, so no access follows it
`timescale 1ns/10ps
module test_phy_basic_ctrl_status_regs;
    import pbc_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [ADDR_W-1:0] addr = '0;
    logic [31:0] wdata = '0;
    logic s_spd = 1'b0;
    logic s_an = 1'b0;
    logic link = 1'b1;
    logic fault = 1'b0;
    logic jab = 1'b0;
    logic an_done = 1'b0;
    logic an_fd = 1'b0;
    logic an_spd = 1'b0;
    logic [31:0] rdata;
    logic waitreq, pd, iso, an_en, an_rst, xrst, lpb, colt, fd, spd, irq;
    logic [31:0] q;
    logic [15:0] d;
    int n_errors = 0;
    int n_compared = 0;
    int cyc = 0;
    localparam logic [ADDR_W-1:0] A_CTRL = {IDX_CTRL, 2'b00};
    localparam logic [ADDR_W-1:0] A_STAT = {IDX_STAT, 2'b00};
    localparam logic [ADDR_W-1:0] A_ISTAT = {IDX_IRQ_STAT, 2'b00};

    pbc_regs DUT (.CLK_I(clk), .SYS_RST_I(rst), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
        .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(4'hF), .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq),
        .STRAP_SPEED_100_I(s_spd), .STRAP_AN_EN_I(s_an), .LINK_UP_I(link), .FAR_FAULT_I(fault),
        .JABBER_I(jab), .AN_DONE_I(an_done), .AN_FULL_DUPLEX_I(an_fd), .AN_SPEED_100_I(an_spd),
        .POWER_DOWN_O(pd), .ISOLATE_O(iso), .AN_ENABLE_O(an_en), .AN_RESTART_O(an_rst), .XCVR_RESET_O(xrst),
        .LOOPBACK_O(lpb), .COL_TEST_O(colt), .FULL_DUPLEX_O(fd), .SPEED_100_O(spd), .IRQ_O(irq));

    initial begin
        forever #5 clk = ~clk;
    end

    task automatic print_verdict;
        $display("compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_errors++;
            print_verdict();
        end
    end

    task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] dv, output logic [31:0] r);
        @(posedge clk);
        rd <= !w;
        wr <= w;
        addr <= a;
        wdata <= dv;
        // Request held until the edge that samples waitrequest low; data taken there
        do begin
            @(posedge clk);
        end while (waitreq !== 1'b0);
        r = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask

    // Readable control bits; self-clearing ones never read back
    function automatic logic [15:0] ctrl_exp(input logic [15:0] v);
        return v & 16'h7D80;
    endfunction

    function automatic logic [6:0] outs_exp(input logic [15:0] c, input logic afd, input logic asp);
        return {c[11], c[10], c[12], c[7], c[14], c[12] ? afd : c[8], c[12] ? asp : c[13]};
    endfunction

    initial begin
        void'($urandom(32'h7D18));
        @(posedge clk);
        s_spd <= 1'($urandom);
        s_an <= 1'($urandom);
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        xfer(1'b0, A_CTRL, 32'h0, q);
        chk(q, {16'h0, 2'b00, s_spd, s_an, 12'h100}, "control reset value");
        xfer(1'b0, A_STAT, 32'h0, q);
        chk(q, {16'h0, STAT_FIXED | 16'h0004}, "status after reset");
        $display("test reset done");
        for (int i = 0; i < 10; i++) begin
            d = (i == 0) ? 16'h7780 : (i == 1) ? 16'h0000 : 16'($urandom) & 16'h7780;
            an_fd <= 1'($urandom);
            an_spd <= 1'($urandom);
            xfer(1'b1, A_CTRL, {16'h0, d}, q);
            xfer(1'b0, A_CTRL, 32'h0, q);
            chk(q, {16'h0, ctrl_exp(d)}, "control readback");
            @(negedge clk);
            chk({25'h0, pd, iso, an_en, colt, lpb, fd, spd}, {25'h0, outs_exp(d, an_fd, an_spd)}, "control outputs");
        end
        $display("test control done");
        xfer(1'b1, {IDX_IRQ_MASK, 2'b00}, 32'h2, q);
        @(posedge clk);
        {fault, jab, link, an_done} <= 4'b1101;
        @(posedge clk);
        {fault, jab, link} <= 3'b001;
        repeat (2) @(negedge clk);
        chk({31'h0, irq}, 32'h1, "interrupt raised");
        xfer(1'b0, A_STAT, 32'h0, q);
        chk(q, {16'h0, STAT_FIXED | 16'h0032}, "latched status");
        xfer(1'b0, A_STAT, 32'h0, q);
        chk(q, {16'h0, STAT_FIXED | 16'h0024}, "live status after read");
        xfer(1'b0, A_ISTAT, 32'h0, q);
        chk(q, 32'hF, "interrupt status");
        xfer(1'b1, A_ISTAT, 32'h2, q);
        @(negedge clk);
        chk({31'h0, irq}, 32'h0, "interrupt cleared");
        xfer(1'b0, A_ISTAT, 32'h0, q);
        chk(q, 32'hD, "interrupt status after clear");
        xfer(1'b1, 12'h7F0, 32'hFFFF, q);
        xfer(1'b0, 12'h7F0, 32'h0, q);
        chk(q, 32'h0, "unmapped read");
        $display("test latch and interrupt done");
        xfer(1'b1, A_CTRL, 32'h0800, q);
        xfer(1'b1, A_CTRL, 32'h0000, q);
        @(negedge clk);
        chk({31'h0, xrst}, 32'h1, "transceiver reset on power-up");
        // No access follows leaving power-down
        $display("test power-down done");
        print_verdict();
    end
endmodule

bind pbc_regs pbc_regs_sva u_sva (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
    .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I), .AVS_WRITEDATA_I(AVS_WRITEDATA_I),
    .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .LINK_UP_I(LINK_UP_I),
    .FAR_FAULT_I(FAR_FAULT_I), .JABBER_I(JABBER_I), .AN_DONE_I(AN_DONE_I), .AN_FULL_DUPLEX_I(AN_FULL_DUPLEX_I),
    .POWER_DOWN_O(POWER_DOWN_O), .ISOLATE_O(ISOLATE_O), .AN_ENABLE_O(AN_ENABLE_O), .AN_RESTART_O(AN_RESTART_O),
    .XCVR_RESET_O(XCVR_RESET_O), .COL_TEST_O(COL_TEST_O), .FULL_DUPLEX_O(FULL_DUPLEX_O));
